// ### inc/paper_replot_pkg.sv
// Shared constants and types for the paper feed and replot controller
package paper_replot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Error codes reported to the host
  localparam logic [2:0] ERR_NONE         = 3'h0;
  localparam logic [2:0] ERR_EXTRA_PARAMS = 3'h2;
  localparam logic [2:0] ERR_RANGE        = 3'h3;
  localparam logic [2:0] ERR_OVERFLOW     = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter ranges
  localparam logic signed [31:0] FEED_MIN  = 32'shFF800000;
  localparam logic signed [31:0] FEED_MAX  = 32'sh007FFFFF;
  localparam logic signed [31:0] COUNT_MIN = 32'sh00000001;
  localparam logic signed [31:0] COUNT_MAX = 32'sh00000063;
  localparam logic [6:0]         COUNT_DEF = 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Replot memory sizing
  localparam int BUF_ADDR_W           = 14;
  localparam int POOL_BYTES           = 14'h3200;
  localparam int REPLOT_DEFAULT_BYTES = 14'h26E2;

  ////////////////////////////////////////////////////////////////////////////
  // Command kinds as decoded by the parser ahead of this block
  typedef enum logic [3:0] {
    plot_cmd,
    output_cmd,
    device_ctrl_cmd,
    page_feed_cmd,
    feed_alias_one,
    feed_alias_two,
    sheet_eject_key_not_ready_cmd,
    capture_plot_cmd,
    replay_plot_cmd,
    init_cmd
  } cmd_kind_type;

  // One decoded command; nparams saturates at 2
  typedef struct packed {
    cmd_kind_type       kind;
    logic [1:0]         nparams;
    logic signed [31:0] param;
    logic [7:0]         data;
  } cmd_type;

  // One-cycle requests to the paper path
  typedef struct packed {
    logic eject_rear;
    logic sheet_eject_key_front;
    logic load_sheet;
  } mech_type;

  // Status bits seen by the extended status query
  typedef struct packed {
    logic not_ready;
    logic capture_on;
    logic load_failure_message;
    logic busy;
  } status_type;

endpackage

// ### rtl/paper_feed_and_replot_control.sv
// Paper feed, sheet_eject_key, plot capture and replot command interpreter
`timescale 1ns/1ps
module paper_feed_and_replot_control
  import paper_replot_pkg::*;
#(
  parameter int POOL       = POOL_BYTES,
  parameter int REPLOT_DEF = REPLOT_DEFAULT_BYTES,
  parameter int ADDR_W     = BUF_ADDR_W
)(
  // Clock, reset and enable
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  // Host command stream
  input  wire logic              cmd_valid_in,
  input  wire cmd_type           cmd_in,
  output logic                   cmd_ready_out,
  // Paper path sensors and mode
  input  wire logic              paper_loaded_in,
  input  wire logic              auto_feed_in,
  input  wire logic              tray_filled_in,
  input  wire logic              mech_done_in,
  // Memory allocation, zero selects the default size
  input  wire logic [ADDR_W-1:0] buffer_alloc_in,
  // Paper path requests
  output mech_type               mech_out,
  // Pen drawing stream
  output logic                   draw_valid_out,
  output logic [7:0]             draw_byte_out,
  // Status and errors
  output status_type             status_out,
  output logic [2:0]             error_code_out,
  output logic                   error_strobe_out,
  output logic [6:0]             copies_done_out,
  output logic [6:0]             copies_req_out
);

  typedef enum logic [2:0] {
    st_idle,
    st_eject_wait,
    st_load_wait,
    st_front_wait,
    st_replay_run,
    st_replay_end
  } state_type;

  state_type         state, next_state;
  logic              plotted_on, next_plotted_on;
  logic              end_unready, next_end_unready;
  logic              replaying, next_replaying;
  logic              rd_pend, next_rd_pend;
  logic              paper_prev;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic [ADDR_W-1:0] lim, buf_fill;
  logic [7:0]        buf_rd_data;
  logic              buf_wr_en, buf_clear, buf_rd_en;
  logic              fire, feed_req, feed_force, go_front, go_eject, eject_final;
  status_type        next_status;
  mech_type          next_mech;
  logic              next_cmd_ready, next_draw_valid, next_err_strobe;
  logic [7:0]        next_draw_byte;
  logic [2:0]        next_err_code;
  logic [6:0]        next_copies_done, next_copies_req;

  ////////////////////////////////////////////////////////////////////////////
  // Replot byte store
  replot_buffer #(
    .DEPTH  (POOL),
    .ADDR_W (ADDR_W)
  ) u_buffer (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .clear_in    (buf_clear),
    .wr_en_in    (buf_wr_en),
    .wr_data_in  (cmd_in.data),
    .rd_en_in    (buf_rd_en),
    .rd_addr_in  (rd_addr),
    .rd_data_out (buf_rd_data),
    .fill_out    (buf_fill)
  );

  // Effective replot size, clamped to the pool
  assign lim = (buffer_alloc_in == '0) ? ADDR_W'(REPLOT_DEF) :
               (buffer_alloc_in > ADDR_W'(POOL)) ? ADDR_W'(POOL) : buffer_alloc_in;
  assign fire = cmd_valid_in && cmd_ready_out;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and paper sequencing
  always_comb
  begin
    next_state       = state;
    next_plotted_on  = plotted_on;
    next_end_unready = end_unready;
    next_replaying   = replaying;
    next_rd_addr     = rd_addr;
    next_rd_pend     = 1'b0;
    next_status      = status_out;
    next_mech        = '0;
    next_draw_valid  = rd_pend;
    next_draw_byte   = buf_rd_data;
    next_err_code    = error_code_out;
    next_err_strobe  = 1'b0;
    next_copies_done = copies_done_out;
    next_copies_req  = copies_req_out;
    buf_wr_en        = 1'b0;
    buf_clear        = 1'b0;
    buf_rd_en        = 1'b0;
    feed_req         = 1'b0;
    feed_force       = 1'b0;
    go_front         = 1'b0;
    go_eject         = 1'b0;
    eject_final      = 1'b1;
    // A new sheet ends not-ready; later sets in this cycle win
    if (paper_loaded_in && !paper_prev)
      next_status.not_ready = 1'b0;
    unique case (state)
      st_idle:
        if (fire)
        begin
          unique case (cmd_in.kind)
            plot_cmd:
            begin
              if (!status_out.not_ready)
              begin
                next_draw_valid = 1'b1;
                next_draw_byte  = cmd_in.data;
                next_plotted_on = 1'b1;
              end
              if (status_out.capture_on)
              begin
                if (buf_fill >= lim)
                begin
                  buf_clear              = 1'b1;
                  next_status.capture_on = 1'b0;
                  next_err_code          = ERR_OVERFLOW;
                  next_err_strobe        = 1'b1;
                end
                else
                  buf_wr_en = 1'b1;
              end
            end
            output_cmd, device_ctrl_cmd: ;
            page_feed_cmd:
            begin
              if (cmd_in.nparams > 2'd1)
              begin
                next_err_code   = ERR_EXTRA_PARAMS;
                next_err_strobe = 1'b1;
              end
              if (cmd_in.nparams != 2'd0 &&
                  (cmd_in.param < FEED_MIN || cmd_in.param > FEED_MAX))
              begin
                next_err_code   = ERR_RANGE;
                next_err_strobe = 1'b1;
              end
              else
              begin
                feed_req   = 1'b1;
                feed_force = (cmd_in.nparams != 2'd0);
              end
            end
            feed_alias_one, feed_alias_two:
              feed_req = 1'b1;
            sheet_eject_key_not_ready_cmd:
            begin
              if (cmd_in.nparams != 2'd0)
              begin
                next_err_code   = ERR_EXTRA_PARAMS;
                next_err_strobe = 1'b1;
              end
              if (!paper_loaded_in)
                next_status.not_ready = 1'b1;
              else if (auto_feed_in)
                go_eject = 1'b1;
              else
                go_front = 1'b1;
            end
            capture_plot_cmd:
            begin
              if (cmd_in.nparams != 2'd0)
              begin
                next_err_code   = ERR_EXTRA_PARAMS;
                next_err_strobe = 1'b1;
              end
              next_status.capture_on = 1'b1;
            end
            replay_plot_cmd:
            begin
              if (cmd_in.nparams > 2'd1)
              begin
                next_err_code   = ERR_EXTRA_PARAMS;
                next_err_strobe = 1'b1;
              end
              if (cmd_in.nparams != 2'd0 &&
                  (cmd_in.param < COUNT_MIN || cmd_in.param > COUNT_MAX))
              begin
                next_err_code   = ERR_RANGE;
                next_err_strobe = 1'b1;
              end
              else if (buf_fill != '0 && !status_out.not_ready)
              begin
                next_status.capture_on           = 1'b0;
                next_status.load_failure_message = 1'b0;
                next_copies_req  = (cmd_in.nparams == 2'd0) ? COUNT_DEF :
                                   cmd_in.param[6:0];
                next_copies_done = 7'h00;
                next_replaying   = 1'b1;
                next_rd_addr     = '0;
                next_state       = st_replay_run;
              end
            end
            init_cmd:
            begin
              buf_clear                        = 1'b1;
              next_status.capture_on           = 1'b0;
              next_status.load_failure_message = 1'b0;
            end
            default: ;
          endcase
        end
      st_eject_wait:
        if (mech_done_in)
        begin
          if (end_unready)
          begin
            next_status.not_ready = 1'b1;
            next_replaying        = 1'b0;
            next_state            = st_idle;
          end
          else
          begin
            next_mech.load_sheet = 1'b1;
            next_state           = st_load_wait;
          end
        end
      st_load_wait:
        if (mech_done_in)
        begin
          next_plotted_on = 1'b0;
          if (replaying && copies_done_out < copies_req_out)
          begin
            next_rd_addr = '0;
            next_state   = st_replay_run;
          end
          else
          begin
            next_replaying = 1'b0;
            next_state     = st_idle;
          end
        end
      st_front_wait:
        if (mech_done_in)
        begin
          next_status.not_ready = 1'b1;
          next_replaying        = 1'b0;
          next_state            = st_idle;
        end
      st_replay_run:
        if (rd_addr < buf_fill)
        begin
          buf_rd_en       = 1'b1;
          next_rd_pend    = 1'b1;
          next_rd_addr    = rd_addr + ADDR_W'(1);
          next_plotted_on = 1'b1;
        end
        else
          next_state = st_replay_end;
      st_replay_end:
      begin
        next_copies_done = copies_done_out + 7'h01;
        if (!auto_feed_in)
          go_front = 1'b1;
        else if (!tray_filled_in)
        begin
          next_status.load_failure_message = 1'b1;
          go_eject                         = 1'b1;
        end
        else
        begin
          go_eject    = 1'b1;
          eject_final = 1'b0;
        end
      end
      default: next_state = st_idle;
    endcase
    // Shared page feed decision
    if (feed_req)
    begin
      next_status.load_failure_message = 1'b0;
      if (!paper_loaded_in)
        next_status.not_ready = 1'b1;
      else if (!auto_feed_in)
        go_front = 1'b1;
      else if (feed_force || plotted_on)
      begin
        go_eject = 1'b1;
        if (!tray_filled_in)
          next_status.load_failure_message = 1'b1;
        else
          eject_final = 1'b0;
      end
    end
    // Launch of a paper motion
    if (go_front)
    begin
      next_mech.sheet_eject_key_front = 1'b1;
      next_state             = st_front_wait;
    end
    if (go_eject)
    begin
      next_mech.eject_rear = 1'b1;
      next_end_unready     = eject_final;
      next_state           = st_eject_wait;
    end
    next_status.busy = (next_state != st_idle);
    next_cmd_ready   = (next_state == st_idle);
  end

  // State and output registers
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state            <= st_idle;
      plotted_on       <= 1'b0;
      end_unready      <= 1'b0;
      replaying        <= 1'b0;
      rd_addr          <= '0;
      rd_pend          <= 1'b0;
      paper_prev       <= 1'b1; // A sheet present at reset is no load event
      status_out       <= '0;
      mech_out         <= '0;
      cmd_ready_out    <= 1'b0;
      draw_valid_out   <= 1'b0;
      draw_byte_out    <= 8'h00;
      error_code_out   <= ERR_NONE;
      error_strobe_out <= 1'b0;
      copies_done_out  <= 7'h00;
      copies_req_out   <= 7'h00;
    end
    else if (ce_in)
    begin
      state            <= next_state;
      plotted_on       <= next_plotted_on;
      end_unready      <= next_end_unready;
      replaying        <= next_replaying;
      rd_addr          <= next_rd_addr;
      rd_pend          <= next_rd_pend;
      paper_prev       <= paper_loaded_in;
      status_out       <= next_status;
      mech_out         <= next_mech;
      cmd_ready_out    <= next_cmd_ready;
      draw_valid_out   <= next_draw_valid;
      draw_byte_out    <= next_draw_byte;
      error_code_out   <= next_err_code;
      error_strobe_out <= next_err_strobe;
      copies_done_out  <= next_copies_done;
      copies_req_out   <= next_copies_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_nopaper_unready;
    ce_in && fire && cmd_in.kind == feed_alias_one && !paper_loaded_in |=> status_out.not_ready;
  endproperty
  a_nopaper_unready: assert property (p_nopaper_unready) else $error("feed no paper");

  property p_manual_front;
    ce_in && fire && cmd_in.kind == feed_alias_two && paper_loaded_in && !auto_feed_in
      |=> mech_out.sheet_eject_key_front && !cmd_ready_out;
  endproperty
  a_manual_front: assert property (p_manual_front) else $error("manual feed");

  property p_forced_eject;
    ce_in && fire && cmd_in.kind == page_feed_cmd && cmd_in.nparams == 2'd1 &&
      cmd_in.param == 32'sh0 && paper_loaded_in && auto_feed_in && tray_filled_in
      |=> mech_out.eject_rear && !status_out.load_failure_message;
  endproperty
  a_forced_eject: assert property (p_forced_eject) else $error("forced feed");

  property p_blocked_draw;
    ce_in && fire && cmd_in.kind == plot_cmd && status_out.not_ready
      && !(paper_loaded_in && !paper_prev) |=> !draw_valid_out;
  endproperty
  a_blocked_draw: assert property (p_blocked_draw) else $error("drew while unready");

  property p_feed_range;
    ce_in && fire && cmd_in.kind == page_feed_cmd && cmd_in.nparams == 2'd1 &&
      cmd_in.param > FEED_MAX |=> error_strobe_out && error_code_out == ERR_RANGE && cmd_ready_out;
  endproperty
  a_feed_range: assert property (p_feed_range) else $error("feed range");

  property p_extra_params;
    ce_in && fire && cmd_in.kind == capture_plot_cmd && cmd_in.nparams != 2'd0
      |=> error_code_out == ERR_EXTRA_PARAMS && status_out.capture_on;
  endproperty
  a_extra_params: assert property (p_extra_params) else $error("extra params");

  property p_store;
    ce_in && fire && cmd_in.kind == plot_cmd && status_out.capture_on && buf_fill < lim
      |=> buf_fill == $past(buf_fill) + ADDR_W'(1);
  endproperty
  a_store: assert property (p_store) else $error("capture store");

  property p_no_store;
    ce_in && fire && (cmd_in.kind == output_cmd || cmd_in.kind == device_ctrl_cmd)
      |=> $stable(buf_fill);
  endproperty
  a_no_store: assert property (p_no_store) else $error("stored non-plot");

  property p_overflow;
    ce_in && fire && cmd_in.kind == plot_cmd && status_out.capture_on && buf_fill >= lim
      |=> buf_fill == '0 && !status_out.capture_on && error_code_out == ERR_OVERFLOW;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow");

  property p_replay_once;
    ce_in && fire && cmd_in.kind == replay_plot_cmd && cmd_in.nparams == 2'd0 &&
      buf_fill != '0 && !status_out.not_ready |=> copies_req_out == 7'h01 && !cmd_ready_out;
  endproperty
  a_replay_once: assert property (p_replay_once) else $error("default count");

  property p_replay_empty;
    ce_in && fire && cmd_in.kind == replay_plot_cmd && cmd_in.nparams == 2'd0 &&
      buf_fill == '0 |=> cmd_ready_out && $stable(copies_req_out);
  endproperty
  a_replay_empty: assert property (p_replay_empty) else $error("empty replay");

  c_capture:  cover property (fire && cmd_in.kind == capture_plot_cmd);
  c_overflow: cover property (ce_in && fire && buf_clear && status_out.capture_on);
  c_replay:   cover property (state == st_replay_end && auto_feed_in && tray_filled_in);
  c_failure:  cover property (next_status.load_failure_message && go_eject);

endmodule // paper_feed_and_replot_control

// ### rtl/replot_buffer.sv
// Byte store for captured plotting commands
`timescale 1ns/1ps
module replot_buffer
  import paper_replot_pkg::*;
#(
  parameter int DEPTH  = POOL_BYTES,
  parameter int ADDR_W = BUF_ADDR_W
)(
  // Clock, reset and enable
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  // Write side
  input  wire logic              clear_in,
  input  wire logic              wr_en_in,
  input  wire logic [7:0]        wr_data_in,
  // Read side
  input  wire logic              rd_en_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [7:0]             rd_data_out,
  output logic [ADDR_W-1:0]      fill_out
);

  logic [7:0]        mem [DEPTH];
  logic [ADDR_W-1:0] next_fill;
  logic [7:0]        next_rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Fill level and read data
  always_comb
  begin
    next_fill    = fill_out;
    next_rd_data = rd_data_out;
    if (clear_in)
      next_fill = '0;
    else if (wr_en_in)
      next_fill = fill_out + ADDR_W'(1);
    if (rd_en_in)
      next_rd_data = mem[rd_addr_in];
  end

  // Register fill and read data
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      fill_out    <= '0;
      rd_data_out <= 8'h00;
    end
    else if (ce_in)
    begin
      fill_out    <= next_fill;
      rd_data_out <= next_rd_data;
    end
  end

  // Storage array, no reset
  always_ff @(posedge clk_in)
  begin
    if (ce_in && wr_en_in && !clear_in)
      mem[fill_out] <= wr_data_in;
  end

endmodule // replot_buffer

// ### sim/paper_feed_and_replot_control_tb_top.sv
// Self-checking bench for the paper feed and replot controller
`timescale 1ns/1ps
module paper_feed_and_replot_control_tb_top import paper_replot_pkg::*;;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       cmd_valid_in = 1'b0;
  cmd_type    cmd_in = '0;
  logic       auto_feed_in = 1'b1;
  logic       tray_filled_in = 1'b1;
  logic       hand_load = 1'b0;
  logic       cmd_ready_out, paper_loaded_in, mech_done_in;
  logic       draw_valid_out, error_strobe_out;
  logic [7:0] draw_byte_out, last;
  logic [2:0] error_code_out;
  logic [6:0] copies_done_out, copies_req_out;
  logic [13:0] alloc = 14'h0000;
  mech_type   mech_out;
  status_type status_out;
  logic [7:0] draw_q[$], cap_q[$];
  logic [2:0] err_q[$];
  int         errors = 0, compares = 0, cycles = 0, seed = 591;
  int         ejects = 0, loads = 0, fronts = 0;

  paper_feed_and_replot_control u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .paper_loaded_in(paper_loaded_in), .auto_feed_in(auto_feed_in),
    .tray_filled_in(tray_filled_in), .mech_done_in(mech_done_in), .buffer_alloc_in(alloc),
    .mech_out(mech_out), .draw_valid_out(draw_valid_out), .draw_byte_out(draw_byte_out),
    .status_out(status_out), .error_code_out(error_code_out),
    .error_strobe_out(error_strobe_out), .copies_done_out(copies_done_out),
    .copies_req_out(copies_req_out));
  paper_path_model u_paper (.clk_in(clk_in), .resetn_in(resetn_in), .mech_in(mech_out),
    .tray_filled_in(tray_filled_in), .hand_load_in(hand_load),
    .mech_done_out(mech_done_in), .paper_loaded_out(paper_loaded_in));

  always #5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Present one command and hold it until taken
  task automatic send(input cmd_kind_type k, input logic [1:0] np, input int p, input logic dr);
    last = 8'($random(seed));
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= '{k, np, p, last};
    if (dr)
      draw_q.push_back(last);
    do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
  endtask

  task automatic plots(input int n, input logic cap, input logic dr);
    repeat (n)
    begin
      send(plot_cmd, 2'h0, 0, dr);
      if (cap)
        cap_q.push_back(last);
    end
  endtask

  // Wait, bounded, until idle, and end on a falling edge
  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk_in);
    while ((cmd_ready_out !== 1'b1 || status_out.busy !== 1'b0) && n < 500)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n == 500)
      errors++; // Wait limit counts as a mismatch
    @(negedge clk_in);
  endtask

  task automatic reload(input logic a);
    @(posedge clk_in);
    hand_load <= 1'b1;
    tray_filled_in <= 1'b1;
    auto_feed_in <= a;
    @(posedge clk_in);
    hand_load <= 1'b0;
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watch drawing, errors and paper motions
  always @(negedge clk_in)
  begin
    ejects += int'(mech_out.eject_rear);
    loads += int'(mech_out.load_sheet);
    fronts += int'(mech_out.sheet_eject_key_front);
    if (draw_valid_out === 1'b1)
      chk("draw", draw_q.size() ? draw_q.pop_front() : 8'hXX, draw_byte_out);
    if (error_strobe_out === 1'b1)
      chk("error", err_q.size() ? 8'(err_q.pop_front()) : 8'hXX, 8'(error_code_out));
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    err_q.push_back(ERR_EXTRA_PARAMS);
    send(capture_plot_cmd, 2'h1, 0, 1'b0);
    plots(3, 1'b1, 1'b1);
    send(output_cmd, 2'h0, 0, 1'b0);
    for (int i = 2; i > 0; i--)
    begin
      repeat (i) foreach (cap_q[j]) draw_q.push_back(cap_q[j]);
      send(replay_plot_cmd, 2'(i - 1), i, 1'b0);
      idle();
      chk("copies", 8'(i), 8'(copies_done_out));
      chk("copies_req", 8'(i), 8'(copies_req_out));
    end
    chk("capture", 8'h0, 8'(status_out.capture_on));
    chk("loads", 8'h3, 8'(loads));
    for (int j = 0; j < 3; j++)
    begin
      err_q.push_back(ERR_RANGE);
      send(j < 2 ? replay_plot_cmd : page_feed_cmd, 2'h1,
           j == 0 ? 0 : (j == 1 ? 100 : int'(FEED_MAX) + 1), 1'b0);
    end
    send(page_feed_cmd, 2'h0, 0, 1'b0);
    send(feed_alias_one, 2'h0, 0, 1'b0);
    send(feed_alias_two, 2'h1, 9, 1'b0);
    idle();
    chk("loads", 8'h3, 8'(loads));
    send(page_feed_cmd, 2'h1, int'(FEED_MIN), 1'b0);
    idle();
    chk("ejects", 8'h4, 8'(ejects));
    plots(1, 1'b0, 1'b1);
    send(feed_alias_two, 2'h0, 0, 1'b0);
    idle();
    chk("loads", 8'h5, 8'(loads));
    @(posedge clk_in);
    tray_filled_in <= 1'b0;
    send(page_feed_cmd, 2'h1, 5, 1'b0);
    idle();
    chk("fail_msg", 8'h1, 8'(status_out.load_failure_message));
    chk("not_ready", 8'h1, 8'(status_out.not_ready));
    plots(1, 1'b0, 1'b0);
    send(page_feed_cmd, 2'h0, 0, 1'b0);
    idle();
    chk("ejects", 8'h6, 8'(ejects));
    reload(1'b0);
    chk("not_ready", 8'h0, 8'(status_out.not_ready));
    // Manual replot: one copy only, then sheet_eject_key to the front
    foreach (cap_q[j]) draw_q.push_back(cap_q[j]);
    send(replay_plot_cmd, 2'h1, 3, 1'b0);
    idle();
    chk("copies_req", 8'h3, 8'(copies_req_out));
    chk("copies", 8'h1, 8'(copies_done_out));
    chk("fronts", 8'h1, 8'(fronts));
    chk("not_ready", 8'h1, 8'(status_out.not_ready));
    reload(1'b0);
    send(page_feed_cmd, 2'h1, 1, 1'b0);
    idle();
    chk("fronts", 8'h2, 8'(fronts));
    reload(1'b0);
    err_q.push_back(ERR_EXTRA_PARAMS);
    send(sheet_eject_key_not_ready_cmd, 2'h1, 0, 1'b0);
    idle();
    chk("fronts", 8'h3, 8'(fronts));
    send(sheet_eject_key_not_ready_cmd, 2'h0, 0, 1'b0);
    send(init_cmd, 2'h0, 0, 1'b0);
    idle();
    chk("not_ready", 8'h1, 8'(status_out.not_ready));
    reload(1'b1);
    send(replay_plot_cmd, 2'h0, 0, 1'b0);
    idle();
    // Small replot size: third captured byte overflows, still drawn
    @(posedge clk_in);
    alloc <= 14'h0002;
    err_q.push_back(ERR_OVERFLOW);
    send(capture_plot_cmd, 2'h0, 0, 1'b0);
    plots(3, 1'b0, 1'b1);
    idle();
    chk("capture", 8'h0, 8'(status_out.capture_on));
    send(replay_plot_cmd, 2'h0, 0, 1'b0);
    idle();
    chk("pending", 8'h0, 8'(ejects + draw_q.size() + err_q.size() - 6));
    end_of_test();
  end
endmodule // paper_feed_and_replot_control_tb_top

// ### sim/paper_path_model.sv
// Paper path model answering motion requests after a varying delay
`timescale 1ns/1ps
module paper_path_model
  import paper_replot_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_in,
  input  wire logic     resetn_in,
  // Requests and operator actions
  input  wire mech_type mech_in,
  input  wire logic     tray_filled_in,
  input  wire logic     hand_load_in,
  // Answers
  output logic          mech_done_out,
  output logic          paper_loaded_out
);
  logic [3:0] wait_cnt;
  mech_type   pend;
  logic       slow;

  // Time a motion, alternating prompt and slow, then move the sheet
  always_ff @(posedge clk_in)
  begin
    mech_done_out <= 1'b0;
    if (!resetn_in)
    begin
      wait_cnt         <= 4'h0;
      pend             <= '0;
      slow             <= 1'b0;
      paper_loaded_out <= 1'b1;
    end
    else if (mech_in != 3'h0)
    begin
      pend     <= mech_in;
      wait_cnt <= slow ? 4'h9 : 4'h1;
      slow     <= !slow;
    end
    else if (wait_cnt != 4'h0)
    begin
      wait_cnt <= wait_cnt - 4'h1;
      if (wait_cnt == 4'h1)
      begin
        mech_done_out    <= 1'b1;
        paper_loaded_out <= pend.load_sheet & tray_filled_in; // Load fails on empty tray
      end
    end
    else if (hand_load_in)
      paper_loaded_out <= 1'b1;
  end
endmodule // paper_path_model
